// ==== bench/launch_token_checker_chk.sv ====
// Checker: bus handshake and verdict timing at the top ports
`timescale 1ns/1ps
module launch_token_checker_chk (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   input  wire logic        err_o,
   input  wire logic        init_permit_o,
   input  wire logic        init_refuse_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] since_start;
   wire  logic take = cyc_i && stb_i && !ack_o && !err_o;
   // Cycles since the last accepted start, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i)
         since_start <= 8'hFF;
      else if (take && we_i && adr_i == permit_pkg::REG_CTRL && dat_i[0])
         since_start <= 8'h00;
      else if (since_start != 8'hFF)
         since_start <= since_start + 8'h01;
   end
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held past one cycle");
   ack_timing_a: assert property (take |=> ack_o || err_o)
      else $error("request not answered next cycle");
   ack_cause_a: assert property ((ack_o || err_o) |-> $past(take))
      else $error("answer without request");
   ack_err_excl_a: assert property (!(ack_o && err_o))
      else $error("ack and err together");
   unmapped_err_a: assert property (take && adr_i inside {[8'h28:8'h7C]}
      |=> err_o && !ack_o) else $error("unmapped access not refused");
   key_read_zero_a: assert property (take && !we_i
      && adr_i == permit_pkg::REG_KEY |=> ack_o && dat_o == 32'h0000_0000)
      else $error("key readback not zero");
   verdict_excl_a: assert property (!(init_permit_o && init_refuse_o))
      else $error("permit and refuse together");
   verdict_cause_a: assert property ($rose(init_permit_o)
      || $rose(init_refuse_o) |-> since_start inside {[8'd1:8'd200]})
      else $error("verdict without recent start");
endmodule : launch_token_checker_chk
bind launch_token_checker launch_token_checker_chk i_chk (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .err_o(err_o), .init_permit_o(init_permit_o),
   .init_refuse_o(init_refuse_o));

// ==== bench/launch_token_checker_tb.sv ====
// Testbench: loads records, runs checks, judges answers from a queue
`timescale 1ns/1ps
module launch_token_checker_tb;
   typedef struct packed {logic e; logic c; logic [31:0] d;} note_t;
   logic        clk_i, rst_i, cyc, stb, we;
   logic [7:0]  adr;
   logic [31:0] dat, key;
   logic [127:0] attr;
   logic [31:0] exp_st [7];
   wire  [31:0] dat_o;
   wire         ack_o, err_o, permit, refuse;
   note_t       q [$];
   note_t       nt;
   int          n_mismatch = 0, n_compared = 0, seed = 91;
   launch_token_checker i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
      .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
      .init_permit_o(permit), .init_refuse_o(refuse));
   permit_producer i_prod ();
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic cmp_data(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : cmp_data
   task automatic cmp_flag(input logic g, input logic x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error at %0t: flag %h expected %h", $time, g, x);
      end
   endtask : cmp_flag
   // Classic cycle held until the answer edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input note_t n);
      q.push_back(n);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, '{1'b0, 1'b0, 32'h0});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0, '{1'b0, 1'b1, x});
   endtask : rd
   function automatic logic [31:0] fold(input int b);
      logic [31:0] x = 32'h0;
      for (int i = 0; i < 8; i++)
         x ^= i_prod.rec[b + i];
      return x;
   endfunction : fold
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   // Oldest note judges each answer
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 || err_o === 1'b1) begin
         nt = q.pop_front();
         cmp_flag(err_o, nt.e);
         if (nt.c)
            cmp_data(dat_o, nt.d);
      end
   end
   // Hang guard, far beyond seven record runs
   initial begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {rst_i, cyc, stb, we, adr, dat} = {1'b1, 3'h0, 8'h00, 32'h0};
      exp_st = '{32'h6, 32'hA, 32'h12, 32'h22, 32'h42, 32'h6, 32'h42};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(permit_pkg::REG_STATUS, permit_pkg::RST_ZERO);
      rd(permit_pkg::REG_BASE, permit_pkg::RST_ZERO);
      bus(1'b0, 8'h40, 32'h0, '{1'b1, 1'b0, 32'h0});
      // Clean, misplaced, invalid, attr, code, uncovered, key cases
      for (int k = 0; k < 7; k++) begin
         key = $random(seed);
         attr = {$random(seed), $random(seed), $random(seed), $random(seed)};
         i_prod.build(key, attr, k, seed);
         wr(permit_pkg::REG_WIDX, 32'h0);
         for (int i = 0; i < 76; i++)
            wr(permit_pkg::REG_WDATA, i_prod.rec[i]);
         wr(permit_pkg::REG_KEY, key);
         for (int i = 0; i < 4; i++)
            wr(permit_pkg::REG_ATTR + 8'(4 * i),
               attr[32*i +: 32] ^ 32'(k == 3 && i == 0));
         wr(permit_pkg::REG_BASE, (k == 1) ? 32'h540 : 32'h400);
         wr(permit_pkg::REG_CTRL, 32'h0000_0001);
         repeat (2) @(posedge clk_i);
         for (int i = 0; i < 300 && permit !== 1'b1 && refuse !== 1'b1; i++)
            @(posedge clk_i);
         #1;
         cmp_flag(permit, exp_st[k][2]);
         cmp_flag(refuse, !exp_st[k][2]);
         rd(permit_pkg::REG_STATUS, exp_st[k]);
         rd(permit_pkg::REG_KEY, 32'h0);
         rd(permit_pkg::REG_WBASE, fold(16));
         rd(permit_pkg::REG_WBASE + 8'h04, fold(32));
      end
      tally_and_finish();
   end
endmodule : launch_token_checker_tb

// ==== bench/permit_producer.sv ====
// Launcher model: builds one permit record in memory
`timescale 1ns/1ps
module permit_producer;
   logic [31:0] rec [76];
   // Modes 2, 4, 5 and 6 pick one flaw; 0, 1 and 3 give a clean record
   task automatic build(input logic [31:0] key, input logic [127:0] attr,
                        input int mode, inout int s);
      logic [31:0] acc;
      logic [31:0] n;
      for (int i = 0; i < 76; i++)
         rec[i] = $random(s);
      // validity word, reserved bits set in mode 2
      rec[0] = (mode == 2) ? 32'hFFFF_FFFE : 32'h0000_0001;
      for (int i = 1; i < 48; i++)
         if (i < 12 || (i > 23 && i < 32) || i > 39)
            rec[i] = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
         rec[12 + i] = attr[32*i +: 32];
      for (int i = 0; i < 4; i++)
         rec[60 + i] = attr[32*i +: 32] & rec[60 + i];
      rec[53] = {24'h00_0000, rec[53][7:0] & rec[53][15:8]};
      rec[59] = rec[59] & $random(s);
      // code over covered words, wrong key in mode 6
      acc = permit_pkg::MAC_SEED;
      for (int i = 0; i < 48; i++)
         acc = {acc[26:0], acc[31:27]} ^ rec[i] ^ key ^ (mode == 6);
      n = 32'h0000_0000;
      for (int i = 64; i < 72; i++)
         n = {n[30:0], n[31]} ^ rec[i];
      rec[75] = acc ^ n ^ rec[72] ^ rec[73] ^ rec[74];
      if (mode == 4)
         rec[75] = ~rec[75];
      if (mode == 5)
         rec[48] = ~rec[48];
   endtask : build
endmodule : permit_producer

// ==== verilog/launch_token_checker.sv ====
// Launch permit record checker with classic Wishbone register slave
`timescale 1ns/1ps
module launch_token_checker (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   output logic             init_permit_o,
   output logic             init_refuse_o
);
   // Word windows in ptr terms; ptr runs one ahead of the word on ram_rdata
   localparam logic [6:0] P_VALID  = 7'(permit_pkg::OFS_VALID / 4 + 1);
   localparam logic [6:0] P_ATTR   = 7'(permit_pkg::OFS_ATTR / 4 + 1);
   localparam logic [6:0] P_BUILD  = 7'(permit_pkg::OFS_BUILD / 4 + 1);
   localparam logic [6:0] P_SIGNER = 7'(permit_pkg::OFS_SIGNER / 4 + 1);
   localparam logic [6:0] P_NONCE  = 7'(permit_pkg::OFS_NONCE / 4 + 1);
   localparam logic [6:0] P_MAC    = 7'(permit_pkg::OFS_MAC / 4 + 1);
   logic [31:0] ctrl_start;
   logic [31:0] base_addr;
   logic [31:0] key_word;
   logic [31:0] attr_exp [0:3];
   logic [6:0]  widx;
   logic [6:0]  ptr;
   logic [31:0] acc;
   logic [31:0] nonce_mix;
   logic [31:0] attr_diff;
   logic [31:0] mac_got;
   logic [31:0] build_fold;
   logic [31:0] signer_fold;
   logic        valid_bit;
   logic        busy;
   logic        done;
   logic        permit;
   logic        f_align;
   logic        f_invalid;
   logic        f_attr;
   logic        f_mac;
   logic [31:0] rd_word;
   logic        req;
   logic        hit_ram;
   logic        ram_we;
   logic [6:0]  ram_raddr;
   logic [31:0] ram_rdata;
   logic [31:0] next_dat;
   logic        next_err;
   permit_pkg::check_state_t state;

   assign req       = cyc_i && stb_i && !ack_o && !err_o;
   assign hit_ram   = adr_i == permit_pkg::REG_WDATA;
   assign ram_we    = req && we_i && hit_ram && !busy;
   assign ram_raddr = busy ? ptr : widx;

   permit_ram u_ram (
      .clk_i   (clk_i),
      .we_i    (ram_we),
      .waddr_i (widx),
      .wdata_i (dat_i),
      .raddr_i (ram_raddr),
      .rdata_o (ram_rdata)
   );

   // Read mux, unmapped addresses answer with err
   always_comb begin
      next_dat = permit_pkg::RST_ZERO;
      next_err = 1'b0;
      if (adr_i == permit_pkg::REG_CTRL) begin
         next_dat = permit_pkg::RST_ZERO;
      end else if (adr_i == permit_pkg::REG_STATUS) begin
         next_dat = {25'h0, f_mac, f_attr, f_invalid, f_align, permit,
                     done, busy};
      end else if (adr_i == permit_pkg::REG_BASE) begin
         next_dat = base_addr;
      end else if (adr_i == permit_pkg::REG_KEY) begin
         next_dat = permit_pkg::RST_ZERO; // Key is write-only
      end else if (adr_i >= permit_pkg::REG_ATTR && adr_i < 8'h20) begin
         next_dat = attr_exp[adr_i[3:2]];
      end else if (adr_i == permit_pkg::REG_WIDX) begin
         next_dat = {25'h0, widx};
      end else if (adr_i == permit_pkg::REG_WDATA) begin
         next_dat = permit_pkg::RST_ZERO;
      end else if (adr_i == permit_pkg::REG_WBASE) begin
         next_dat = build_fold;
      end else if (adr_i == 8'h84) begin
         next_dat = signer_fold;
      end else begin
         next_err = 1'b1;
      end
   end

   // Bus answer one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= permit_pkg::RST_ZERO;
      end else begin
         ack_o <= req && !next_err;
         err_o <= req && next_err;
         dat_o <= req ? next_dat : permit_pkg::RST_ZERO;
      end
   end

   // Software writes; record loading blocked while busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_addr  <= permit_pkg::RST_ZERO;
         key_word   <= permit_pkg::RST_ZERO;
         widx       <= 7'h00;
         ctrl_start <= permit_pkg::RST_ZERO;
         for (int i = 0; i < 4; i++) attr_exp[i] <= permit_pkg::RST_ZERO;
      end else begin
         ctrl_start <= permit_pkg::RST_ZERO;
         if (req && we_i && !busy) begin
            if (adr_i == permit_pkg::REG_CTRL) begin
               ctrl_start <= dat_i;
            end else if (adr_i == permit_pkg::REG_BASE) begin
               base_addr <= dat_i;
            end else if (adr_i == permit_pkg::REG_KEY) begin
               key_word <= dat_i;
            end else if (adr_i >= permit_pkg::REG_ATTR && adr_i < 8'h20) begin
               attr_exp[adr_i[3:2]] <= dat_i;
            end else if (adr_i == permit_pkg::REG_WIDX) begin
               widx <= dat_i[6:0];
            end else if (hit_ram) begin
               widx <= widx + 7'h01; // Auto-advance for streaming loads
            end
         end
      end
   end

   // Check sequencer: walks the record once, one word per cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state       <= permit_pkg::IDLE;
         ptr         <= 7'h00;
         busy        <= 1'b0;
         done        <= 1'b0;
         permit      <= 1'b0;
         f_align     <= 1'b0;
         f_invalid   <= 1'b0;
         f_attr      <= 1'b0;
         f_mac       <= 1'b0;
         acc         <= permit_pkg::RST_ZERO;
         nonce_mix   <= permit_pkg::RST_ZERO;
         attr_diff   <= permit_pkg::RST_ZERO;
         mac_got     <= permit_pkg::RST_ZERO;
         build_fold  <= permit_pkg::RST_ZERO;
         signer_fold <= permit_pkg::RST_ZERO;
         valid_bit   <= 1'b0;
         rd_word     <= permit_pkg::RST_ZERO;
      end else begin
         case (state)
            permit_pkg::IDLE: begin
               if (ctrl_start[permit_pkg::CTRL_START]) begin
                  busy      <= 1'b1;
                  done      <= 1'b0;
                  permit    <= 1'b0;
                  ptr       <= 7'h00;
                  acc       <= permit_pkg::MAC_SEED;
                  nonce_mix <= permit_pkg::RST_ZERO;
                  attr_diff <= permit_pkg::RST_ZERO;
                  mac_got   <= permit_pkg::RST_ZERO;
                  f_align   <= base_addr[8:0] != 9'h000;
                  state     <= permit_pkg::LOAD;
               end
            end
            permit_pkg::LOAD: begin
               ptr   <= ptr + 7'h01; // RAM read latency of one cycle
               state <= permit_pkg::MIX;
            end
            permit_pkg::MIX: begin
               // Word at ptr-1 is now on ram_rdata
               rd_word <= ram_rdata;
               if (ptr == P_VALID) begin
                  valid_bit <= ram_rdata[permit_pkg::VALID_BIT];
               end
               if (ptr >= P_ATTR && ptr < P_ATTR + 7'd4) begin
                  attr_diff <= attr_diff |
                               (ram_rdata ^ attr_exp[2'(ptr - P_ATTR)]);
               end
               if (ptr >= P_BUILD && ptr < P_BUILD + 7'd8) begin
                  build_fold <= (ptr == P_BUILD) ? ram_rdata
                                                 : build_fold ^ ram_rdata;
               end
               if (ptr >= P_SIGNER && ptr < P_SIGNER + 7'd8) begin
                  signer_fold <= (ptr == P_SIGNER) ? ram_rdata
                                                   : signer_fold ^ ram_rdata;
               end
               // code covers first 48 words only
               if (ptr <= 7'(permit_pkg::COVER_WORDS)) begin
                  acc <= {acc[26:0], acc[31:27]} ^ ram_rdata ^ key_word;
               end
               if (ptr >= P_NONCE && ptr < P_NONCE + 7'd8) begin
                  nonce_mix <= {nonce_mix[30:0], nonce_mix[31]} ^ ram_rdata;
               end
               // stored code, folded from four words
               if (ptr >= P_MAC && ptr <= 7'(permit_pkg::REC_WORDS)) begin
                  mac_got <= mac_got ^ ram_rdata;
               end
               if (ptr == 7'(permit_pkg::REC_WORDS)) begin
                  state <= permit_pkg::CHECK;
               end else begin
                  ptr <= ptr + 7'h01;
               end
            end
            permit_pkg::CHECK: begin
               f_invalid <= !valid_bit;
               f_attr    <= attr_diff != permit_pkg::RST_ZERO;
               f_mac     <= (acc ^ nonce_mix) != mac_got;
               state     <= permit_pkg::DONE;
            end
            permit_pkg::DONE: begin
               permit <= !f_align && !f_invalid && !f_attr && !f_mac;
               busy   <= 1'b0;
               done   <= 1'b1;
               state  <= permit_pkg::IDLE;
            end
            default: state <= permit_pkg::IDLE;
         endcase
      end
   end

   // Outcome to the init operation, held in flops until the next start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         init_permit_o <= 1'b0;
         init_refuse_o <= 1'b0;
      end else if (state == permit_pkg::IDLE
                   && ctrl_start[permit_pkg::CTRL_START]) begin
         init_permit_o <= 1'b0; // Stale verdict must not outlive a restart
         init_refuse_o <= 1'b0;
      end else if (state == permit_pkg::DONE) begin
         init_permit_o <= !f_align && !f_invalid && !f_attr && !f_mac;
         init_refuse_o <= f_align || f_invalid || f_attr || f_mac;
      end
   end
endmodule : launch_token_checker

// ==== verilog/permit_pkg.sv ====
// Package: launch permit record layout, register map, status bits and code seed
package permit_pkg;
   // Record layout, byte offsets and sizes
   localparam int unsigned REC_BYTES        = 304;
   localparam int unsigned REC_WORDS        = 76;
   localparam int unsigned ALIGN_BYTES      = 512;
   localparam int unsigned OFS_VALID        = 0;
   localparam int unsigned OFS_ATTR         = 48;
   localparam int unsigned OFS_BUILD        = 64;
   localparam int unsigned OFS_SIGNER       = 128;
   localparam int unsigned OFS_LAUNCHER     = 192;
   localparam int unsigned OFS_FLOW_ATTRS   = 212;
   localparam int unsigned OFS_FRAME_SEL    = 236;
   localparam int unsigned OFS_MASKED_ATTR  = 240;
   localparam int unsigned OFS_NONCE        = 256;
   localparam int unsigned OFS_MAC          = 288;
   localparam int unsigned COVER_WORDS      = 48;
   localparam int unsigned VALID_BIT        = 0;
   // Register byte addresses
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_BASE     = 8'h08;
   localparam logic [7:0] REG_KEY      = 8'h0C;
   localparam logic [7:0] REG_ATTR     = 8'h10;
   localparam logic [7:0] REG_WIDX     = 8'h20;
   localparam logic [7:0] REG_WDATA    = 8'h24;
   localparam logic [7:0] REG_WBASE    = 8'h80;
   // Control and status bits
   localparam int unsigned CTRL_START  = 0;
   localparam int unsigned ST_BUSY     = 0;
   localparam int unsigned ST_DONE     = 1;
   localparam int unsigned ST_PERMIT   = 2;
   localparam int unsigned ST_ALIGN    = 3;
   localparam int unsigned ST_INVALID  = 4;
   localparam int unsigned ST_ATTR     = 5;
   localparam int unsigned ST_MAC      = 6;
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [31:0] MAC_SEED    = 32'h5A5A_A5A5;
   typedef enum logic [2:0] {IDLE, LOAD, MIX, CHECK, DONE} check_state_t;
endpackage : permit_pkg

// ==== verilog/permit_ram.sv ====
// Record buffer: word memory with registered read port
`timescale 1ns/1ps
module permit_ram (
   input  wire logic        clk_i,
   input  wire logic        we_i,
   input  wire logic [6:0]  waddr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [6:0]  raddr_i,
   output logic      [31:0] rdata_o
);
   logic [31:0] mem [0:permit_pkg::REC_WORDS-1];

   // Write port and registered read
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule : permit_ram
